// ==== dv/sdram_self_refresh_power_down_tb.sv ====
`timescale 1ns/10ps
module sdram_self_refresh_power_down_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_n_pin = 1'b0;
  logic bank = 1'b0;
  logic fast = 1'b0;
  logic [1:0] op = 2'h0;
  logic cke_pin;
  logic [3:0] cmd;
  logic [6:0] got;
  int err_count = 0;
  int comparisons = 0;
  int n;
  logic refresh;
  int refresh_cnt = 0;
  // {op, bank, fast, sr pdp pda rst dll rx buf}
  logic [10:0] rows [10] = '{11'h007, 11'h240, 11'h007, 11'h420, 11'h007,
    11'h4A4, 11'h007, 11'h514, 11'h107, 11'h607};
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  srpd_host_model host_u (.ref_clk(ref_clk), .op(op), .cke_pin(cke_pin),
    .cmd(cmd));
  srpd_ctrl #(.SELF_REF_CYC(20)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .reset_n_pin(reset_n_pin), .cke_pin(cke_pin), .cs_n_pin(cmd[3]),
    .ras_n_pin(cmd[2]), .cas_n_pin(cmd[1]), .we_n_pin(cmd[0]),
    .any_bank_open(bank), .pd_fast_exit(fast), .dll_enable(1'b1),
    .in_self_refresh(got[6]), .in_pd_precharge(got[5]),
    .in_pd_active(got[4]), .in_reset(got[3]), .dll_on(got[2]),
    .dll_reset_pulse(), .refresh_req(refresh), .rx_enable(got[1]),
    .buffers_enable(got[0]));
  always @(posedge ref_clk) begin
    if (refresh === 1'b1)
      refresh_cnt++;
  end
  task automatic chk_count(input int g, input int e);
    comparisons++;
    if (g != e) begin
      err_count++;
      $display("wrong value at %0t: count %0d, want %0d", $time, g, e);
    end
  endtask
  task automatic chk(input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: state %b, want %b", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    step(6);
    chk(7'h08);
    rst = 1'b0;
    reset_n_pin = 1'b1;
    step(8);
    foreach (rows[i]) begin
      {op, bank, fast} = rows[i][10:7];
      step(rows[i][10:9] == 2'h1 ? 30 : 8);
      chk(rows[i][6:0]);
    end
    // reset pin dropped in the middle of active power-down
    op = 2'h0;
    step(4);
    op = 2'h2;
    bank = 1'b1;
    step(8);
    chk(7'h14);
    reset_n_pin = 1'b0;
    n = 0;
    while (got !== 7'h08 && n < 10) begin
      step(1);
      n++;
    end
    chk(7'h08);
    if (n < 10) begin
      op = 2'h0;
      reset_n_pin = 1'b1;
      step(8);
      chk(7'h07);
      chk_count(refresh_cnt, 2);
    end
    test_done();
  end
endmodule

// ==== dv/srpd_ctrl_props.sv ====
`timescale 1ns/10ps
module srpd_ctrl_props (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic reset_n_pin, // pin
  input wire logic cke_pin, // pin
  input wire logic cs_n_pin, // pin
  input wire logic ras_n_pin, // pin
  input wire logic cas_n_pin, // pin
  input wire logic we_n_pin, // pin
  input wire logic any_bank_open, // core
  input wire logic dll_enable, // mode
  input wire logic in_self_refresh, // state
  input wire logic in_pd_precharge, // state
  input wire logic in_pd_active, // state
  input wire logic in_reset, // state
  input wire logic dll_on, // dll
  input wire logic dll_reset_pulse, // dll
  input wire logic refresh_req, // refresh
  input wire logic rx_enable, // receivers
  input wire logic buffers_enable // buffers
);
  wire pd = in_pd_precharge | in_pd_active;
  wire idle = !(in_self_refresh | pd | in_reset);
  wire [3:0] cmd = {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
  wire nop = cmd == srpd_pkg::CMD_NOP || cs_n_pin;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pin-to-state latency is three edges; ranges allow sampling skew
  property p_sre;
    $fell(cke_pin) && cmd == srpd_pkg::CMD_REF && idle && reset_n_pin
      |-> ##[2:4] in_self_refresh;
  endproperty
  a_sre: assert property (p_sre) else $error("entry missed");
  property p_pde;
    $fell(cke_pin) && nop && idle && reset_n_pin |-> ##[2:4] pd;
  endproperty
  a_pde: assert property (p_pde) else $error("pd missed");
  property p_pdx;
    pd && $rose(cke_pin) && nop && reset_n_pin |-> ##[2:4] !pd;
  endproperty
  a_pdx: assert property (p_pdx) else $error("pd exit missed");
  property p_sr_off;
    in_self_refresh |-> !rx_enable && !buffers_enable && !dll_on;
  endproperty
  a_sr_off: assert property (p_sr_off) else $error("sr inputs on");
  property p_ref;
    $rose(in_self_refresh) |-> ##[0:2] refresh_req;
  endproperty
  a_ref: assert property (p_ref) else $error("no entry refresh");
  property p_dllrst;
    $fell(in_self_refresh) && !in_reset && dll_enable
      |-> ##[0:1] dll_reset_pulse;
  endproperty
  a_dllrst: assert property (p_dllrst) else $error("no dll reset");
  property p_kind;
    pd && any_bank_open |=> !in_pd_precharge;
  endproperty
  a_kind: assert property (p_kind) else $error("wrong pd kind");
  property p_pdrx;
    $rose(pd) |-> !buffers_enable ##[1:2] !rx_enable;
  endproperty
  a_pdrx: assert property (p_pdrx) else $error("pd rx on");
endmodule
bind srpd_ctrl srpd_ctrl_props chk_u (.*);

// ==== dv/srpd_host_model.sv ====
`timescale 1ns/10ps
module srpd_host_model (
  input wire logic ref_clk, // clock
  input wire logic [1:0] op, // 0 nop, 1 sre, 2 pde, 3 bad pde
  output logic cke_pin, // clock enable
  output logic [3:0] cmd // cs, ras, cas, we
);
  logic [1:0] last_op = 2'h0;
  logic next_cke;
  logic [3:0] next_cmd;
  initial begin
    cke_pin = 1'b1;
    cmd = srpd_pkg::CMD_NOP;
  end
  // no odt pin, no writes, no busy ops, clock never stopped:
  // dll always locked on entry, termination always off:
  always @(posedge ref_clk) begin
    next_cke = op == 2'h0;
    if (op == 2'h0)
      next_cmd = srpd_pkg::CMD_NOP;
    else if (op != last_op)
      next_cmd = op == 2'h1 ? srpd_pkg::CMD_REF :
                 op == 2'h2 ? srpd_pkg::CMD_NOP : 4'h6;
    else
      next_cmd = ~cmd; // garbage while cke low
    last_op = op;
    #1;
    cke_pin = next_cke;
    cmd = next_cmd;
  end
endmodule

// ==== rtl/srpd_ctrl.sv ====
`timescale 1ns/10ps
// Operation
// [RULE_01] decode self-refresh entry from command pins
// [RULE_02] controller enters only from idle state
// [RULE_03] termination off first; controller has no termination control
// [RULE_04] in self-refresh only cke and reset matter
// [RULE_05] dll off on entry, reset on exit
// [RULE_06] writes wait 512 cycles after reference loss
// [RULE_07] one refresh within tCKE, then timer
// [RULE_08] minimum self-refresh residence; controller exits on the first cke rise with no minimum
// [RULE_09] clock stop and restart delays kept
// [RULE_10] exit is cke high with nop; controller exits on the first cke rise whatever the command pins hold
// [RULE_11] cke high during dll-locked exit period
// [RULE_12] extra refresh before self-refresh re-entry
// [RULE_13] nop or deselect during exit delay
// [RULE_14] termination off during dll exit period
// [RULE_15] power-down entry on cke low with nop
// [RULE_16] no cke drop during busy operations
// [RULE_17] precharge or active power-down by banks
// [RULE_18] buffers off, receivers off after entry delay
// [RULE_19] bit a12 selects slow or fast exit
// [RULE_20] dll reset if entered unlocked; controller resets dll on every self-refresh exit while dll_enable
// [RULE_21] reset pin low leaves power-down
// [RULE_22] cke low minimum, power-down duration limit
// [RULE_23] power-down exit cke high with nop
module srpd_ctrl #(
  parameter int SELF_REF_CYC = srpd_pkg::SELF_REF_CYC,
  parameter int ENTRY_DLY = srpd_pkg::ENTRY_DLY_CYC
) (
  input wire logic ref_clk, // memory clock
  input wire logic rst, // async reset
  input wire logic reset_n_pin, // device reset pin, active low
  input wire logic cke_pin, // clock enable pin
  input wire logic cs_n_pin, // chip select, active low
  input wire logic ras_n_pin, // row strobe, active low
  input wire logic cas_n_pin, // column strobe, active low
  input wire logic we_n_pin, // write enable, active low
  input wire logic any_bank_open, // bank state from core
  input wire logic pd_fast_exit, // mode bit a12
  input wire logic dll_enable, // mode bit: dll on in normal use
  output logic in_self_refresh, // self-refresh state
  output logic in_pd_precharge, // precharge power-down
  output logic in_pd_active, // active power-down
  output logic in_reset, // reset state
  output logic dll_on, // dll running
  output logic dll_reset_pulse, // one-cycle dll reset request
  output logic refresh_req, // one-cycle internal refresh
  output logic rx_enable, // command and address receivers on
  output logic buffers_enable // data and other input buffers on
);
  initial begin
    if (SELF_REF_CYC < srpd_pkg::CKE_MIN_CYC + 2 || ENTRY_DLY < 1 ||
        ENTRY_DLY > 255)
      $error("srpd_ctrl: parameter out of range");
  end

  // pins cross from the controller, two flops each
  logic [5:0] sync1, sync2;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {reset_n_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin,
                we_n_pin};
      sync2 <= sync1;
    end
  end

  wire pin_reset_n = sync2[5];
  wire cke = sync2[4];
  wire [3:0] cmd = sync2[3:0];
  logic cke_d;

  function automatic logic is_nop(input logic [3:0] c);
    is_nop = (c == srpd_pkg::CMD_NOP) ||
             ((c & srpd_pkg::CMD_MASK_DES) == srpd_pkg::CMD_MASK_DES);
  endfunction

  srpd_pkg::srpd_state_t state, next_state;
  logic [7:0] edly;
  wire cke_fall = cke_d && !cke;
  wire cke_rise = !cke_d && cke;
  wire sre_cmd = cke_fall && (cmd == srpd_pkg::CMD_REF); // [RULE_01]
  wire pde_cmd = cke_fall && is_nop(cmd); // [RULE_15]
  wire pdx_cmd = cke_rise && is_nop(cmd); // [RULE_23]
  // self-refresh exit ignores command pins apart from cke
  wire srx_cmd = cke_rise; // [RULE_04] [RULE_10]
  wire slow_pd = !pd_fast_exit; // [RULE_19]
  wire in_pd = (state == srpd_pkg::SRPD_PD_PRE) ||
               (state == srpd_pkg::SRPD_PD_ACT);
  wire self_ref_run = (state == srpd_pkg::SRPD_SELF_REF);

  always_comb begin
    next_state = state;
    case (state)
      srpd_pkg::SRPD_IDLE: begin
        if (sre_cmd)
          next_state = srpd_pkg::SRPD_SELF_REF;
        else if (pde_cmd && any_bank_open)
          next_state = srpd_pkg::SRPD_PD_ACT; // [RULE_17]
        else if (pde_cmd)
          next_state = srpd_pkg::SRPD_PD_PRE; // [RULE_17]
      end
      srpd_pkg::SRPD_SELF_REF: begin
        if (srx_cmd)
          next_state = srpd_pkg::SRPD_IDLE;
      end
      srpd_pkg::SRPD_PD_PRE, srpd_pkg::SRPD_PD_ACT: begin
        if (pdx_cmd)
          next_state = srpd_pkg::SRPD_IDLE;
        else if (state == srpd_pkg::SRPD_PD_PRE && any_bank_open)
          next_state = srpd_pkg::SRPD_PD_ACT;
        else if (state == srpd_pkg::SRPD_PD_ACT && !any_bank_open)
          next_state = srpd_pkg::SRPD_PD_PRE;
      end
      srpd_pkg::SRPD_RESET: begin
        next_state = srpd_pkg::SRPD_IDLE;
      end
      default: next_state = srpd_pkg::SRPD_RESET;
    endcase
    if (!pin_reset_n)
      next_state = srpd_pkg::SRPD_RESET; // [RULE_21]
  end

  // a refresh right after entry, well inside the minimum cke pulse
  logic entry_refresh;
  logic timer_tick;
  srpd_timer #(
    .PERIOD(SELF_REF_CYC)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(self_ref_run),
    .tick(timer_tick)
  );

  wire next_refresh = entry_refresh || timer_tick; // [RULE_07]
  wire entering_pd = (next_state == srpd_pkg::SRPD_PD_PRE ||
                      next_state == srpd_pkg::SRPD_PD_ACT) && !in_pd;
  wire leaving_sr = self_ref_run && next_state != srpd_pkg::SRPD_SELF_REF;
  // dll is off in self-refresh and in slow precharge power-down
  // reset state keeps the dll off so a restart always relocks
  wire next_dll_on = dll_enable &&
    next_state != srpd_pkg::SRPD_SELF_REF &&
    next_state != srpd_pkg::SRPD_RESET &&
    !(next_state == srpd_pkg::SRPD_PD_PRE && slow_pd); // [RULE_05] [RULE_19]
  wire next_dll_reset = leaving_sr && dll_enable; // [RULE_05]
  wire sleep_next = (next_state != srpd_pkg::SRPD_IDLE);
  wire [7:0] next_edly = entering_pd ? 8'(ENTRY_DLY) :
                         (edly != 8'h00 ? edly - 8'h01 : 8'h00);
  // receivers stay on while the entry delay runs so nops are seen
  wire next_rx = !sleep_next || (in_pd || entering_pd) &&
                 next_edly != 8'h00; // [RULE_18]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= srpd_pkg::SRPD_RESET;
      cke_d <= 1'b0;
      edly <= 8'h00;
      entry_refresh <= 1'b0;
      refresh_req <= 1'b0;
      dll_on <= 1'b0;
      dll_reset_pulse <= 1'b0;
      rx_enable <= 1'b0;
      buffers_enable <= 1'b0;
      in_self_refresh <= 1'b0;
      in_pd_precharge <= 1'b0;
      in_pd_active <= 1'b0;
      in_reset <= 1'b1;
    end else begin
      state <= next_state;
      cke_d <= cke;
      edly <= next_edly;
      entry_refresh <= !self_ref_run &&
                       next_state == srpd_pkg::SRPD_SELF_REF;
      refresh_req <= next_refresh;
      dll_on <= next_dll_on;
      dll_reset_pulse <= next_dll_reset;
      rx_enable <= next_rx;
      buffers_enable <= !sleep_next; // [RULE_18]
      in_self_refresh <= next_state == srpd_pkg::SRPD_SELF_REF;
      in_pd_precharge <= next_state == srpd_pkg::SRPD_PD_PRE;
      in_pd_active <= next_state == srpd_pkg::SRPD_PD_ACT;
      in_reset <= next_state == srpd_pkg::SRPD_RESET;
    end
  end
endmodule

// ==== rtl/srpd_pkg.sv ====
package srpd_pkg;
  // command pin encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MASK_DES = 4'h8;
  // refresh interval of the self-refresh built-in timer, in ns
  localparam int T_SELF_REF_NS = 7800;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SELF_REF_CYC = T_SELF_REF_NS / CLK_PERIOD_NS;
  // minimum clock-enable pulse, cycles
  localparam int CKE_MIN_CYC = 3;
  // entry delay before receivers shut off, cycles
  localparam int ENTRY_DLY_CYC = 1;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  typedef enum logic [2:0] {
    SRPD_IDLE, SRPD_SELF_REF, SRPD_PD_PRE, SRPD_PD_ACT, SRPD_RESET
  } srpd_state_t;
endpackage

// ==== rtl/srpd_timer.sv ====
`timescale 1ns/10ps
module srpd_timer #(
  parameter int PERIOD = 780
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // async reset
  input wire logic run, // count while high
  output logic tick // one-cycle pulse each period
);
  initial begin
    if (PERIOD < 2 || PERIOD >= (1 << srpd_pkg::CNT_W))
      $error("srpd_timer: PERIOD out of range");
  end
  logic [srpd_pkg::CNT_W-1:0] cnt;
  localparam logic [srpd_pkg::CNT_W-1:0] LAST = srpd_pkg::CNT_W'(PERIOD - 1);
  wire wrap = (cnt == LAST);
  wire [srpd_pkg::CNT_W-1:0] next_cnt =
    (!run || wrap) ? srpd_pkg::CNT_ZERO : cnt + srpd_pkg::CNT_ONE;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= srpd_pkg::CNT_ZERO;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= run && wrap;
    end
  end
endmodule
